// ---- include/sct_map.svh ----
// register map, field positions and timing constants for the serial core
`ifndef SCT_MAP_SVH
`define SCT_MAP_SVH
`define SCT_ADDR_W        3
`define SCT_OFF_STAT1     3'h0
`define SCT_OFF_STAT2     3'h1
`define SCT_OFF_DATA      3'h2
`define SCT_OFF_CTRL1     3'h3
`define SCT_OFF_CTRL2     3'h4
`define SCT_OFF_CTRL3     3'h5
`define SCT_OFF_BAUD      3'h6
`define SCT_C1_LONG       4
`define SCT_C1_ENABLE     6
`define SCT_C2_TXIE       7
`define SCT_C2_TX_COMPLETE_IRQ_ENABLE       6
`define SCT_C2_RXIE       5
`define SCT_C2_RXEN       2
`define SCT_C2_TXEN       3
`define SCT_C2_BREAK      0
`define SCT_C3_TX9        6
`define SCT_C3_RX9        7
`define SCT_S1_TXE        7
`define SCT_S1_TC         6
`define SCT_S1_RXF        5
`define SCT_S1_NF         2
`define SCT_S1_FE         1
`define SCT_S2_BKF        1
`define SCT_S2_RPF        0
`define SCT_BAUD_RST      8'h0f
`define SCT_OVS           4'hf
`define SCT_MID           4'h7
`define SCT_LEN8          4'h9
`define SCT_LEN9          4'ha
`endif

// ---- include/sct_pkg.sv ----
// types shared by the serial core
package sct_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA, TX_BRK} sct_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} sct_rx_t;
endpackage

// ---- hdl/sct_core.sv ----
// full duplex async serial transmitter and receiver with register port
`timescale 1ns/1ps
`include "sct_map.svh"
module sct_core (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   clkEn,
  input  wire logic [`SCT_ADDR_W-1:0] regAddr,
  input  wire logic [7:0]             regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic      [7:0]             regRdata,
  input  wire logic                   rxdPin,
  output logic                        txdOut,
  output logic                        txdOe,
  output logic                        txIrq,
  output logic                        rxIrq
);
  logic [7:0]  ctrl1Reg, ctrl2Reg, baudReg, txBufReg, rxBufReg;
  logic        tx9Reg, rx9Reg;
  logic        txeReg, tcReg, rxfReg, feReg, nfReg, bkfReg;
  logic        txFullReg, stat1SeenReg, idleQReg, teDlyReg;
  logic [7:0]  baudCnt;
  logic        tick;
  logic [10:0] txShReg;
  logic [3:0]  txPh, txBits;
  sct_pkg::sct_tx_t txSt;
  logic        rxS1, rxS2;
  logic [3:0]  rxPh, rxBits;
  logic [9:0]  rxShReg;
  sct_pkg::sct_rx_t rxSt;
  logic        enMod, teBit, longCh, brkBit;
  logic        dataWr, stat1Rd, txLoad, rxDone, rxBreak, preStart;
  logic [3:0]  charLen;

  assign enMod   = ctrl1Reg[`SCT_C1_ENABLE];
  assign longCh  = ctrl1Reg[`SCT_C1_LONG];
  assign teBit   = ctrl2Reg[`SCT_C2_TXEN];
  assign brkBit  = ctrl2Reg[`SCT_C2_BREAK];
  assign charLen = longCh ? `SCT_LEN9 : `SCT_LEN8;
  assign dataWr  = regWr && regAddr == `SCT_OFF_DATA;
  assign stat1Rd = regRd && regAddr == `SCT_OFF_STAT1;

  function automatic logic [10:0] frame(input logic [7:0] d, input logic b9, input logic l);
    frame = l ? {1'b1, b9, d, 1'b0} : {2'b11, d, 1'b0};
  endfunction

  // one baud divider feeds both engines at 16x
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      baudCnt <= 8'h00;
      tick    <= 1'b0;
    end else if (clkEn) begin
      tick    <= baudCnt == 8'h00;
      baudCnt <= (baudCnt == 8'h00 || !enMod) ? baudReg : baudCnt - 8'h01;
    end
  end

  // control registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1Reg <= 8'h00;
      ctrl2Reg <= 8'h00;
      baudReg  <= `SCT_BAUD_RST;
      tx9Reg   <= 1'b0;
    end else if (clkEn && regWr) begin
      if (regAddr == `SCT_OFF_CTRL1) begin
        ctrl1Reg <= regWdata;
      end else if (regAddr == `SCT_OFF_CTRL2) begin
        ctrl2Reg <= regWdata;
      end else if (regAddr == `SCT_OFF_CTRL3) begin
        tx9Reg <= regWdata[`SCT_C3_TX9];
      end else if (regAddr == `SCT_OFF_BAUD) begin
        baudReg <= regWdata;
      end
    end
  end

  // read port, data one cycle after strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (clkEn) begin
      regRdata <= 8'h00;
      if (regRd) begin
        if (regAddr == `SCT_OFF_STAT1) begin
          regRdata <= {txeReg, tcReg, rxfReg, 2'b00, nfReg, feReg, 1'b0};
        end else if (regAddr == `SCT_OFF_STAT2) begin
          regRdata <= {6'h00, bkfReg, rxSt != sct_pkg::RX_IDLE};
        end else if (regAddr == `SCT_OFF_DATA) begin
          regRdata <= rxBufReg;
        end else if (regAddr == `SCT_OFF_CTRL1) begin
          regRdata <= ctrl1Reg;
        end else if (regAddr == `SCT_OFF_CTRL2) begin
          regRdata <= ctrl2Reg;
        end else if (regAddr == `SCT_OFF_CTRL3) begin
          regRdata <= {rx9Reg, tx9Reg, 6'h00};
        end else if (regAddr == `SCT_OFF_BAUD) begin
          regRdata <= baudReg;
        end
      end
    end
  end

  // transmit buffer and empty flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txBufReg     <= 8'h00;
      txFullReg    <= 1'b0;
      txeReg       <= 1'b1;
      stat1SeenReg <= 1'b0;
    end else if (clkEn) begin
      if (stat1Rd && txeReg) begin
        stat1SeenReg <= 1'b1;
      end
      if (dataWr) begin
        txBufReg  <= regWdata;
        txFullReg <= 1'b1;
        if (stat1SeenReg) begin
          txeReg       <= 1'b0;
          stat1SeenReg <= 1'b0;
        end
      end
      if (txLoad) begin
        txFullReg <= dataWr;
        txeReg    <= 1'b1;
      end
    end
  end

  assign preStart = tick && enMod && txSt == sct_pkg::TX_IDLE && teBit && !brkBit && idleQReg;

  // rising transmit enable queues one idle character, set wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      teDlyReg <= 1'b0;
      idleQReg <= 1'b0;
    end else if (clkEn) begin
      teDlyReg <= teBit;
      if (teBit && !teDlyReg) begin
        idleQReg <= 1'b1;
      end else if (preStart) begin
        idleQReg <= 1'b0;
      end
    end
  end

  // transmit engine
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txSt     <= sct_pkg::TX_IDLE;
      txShReg  <= 11'h7ff;
      txPh     <= 4'h0;
      txBits   <= 4'h0;
      tcReg    <= 1'b1;
      txLoad   <= 1'b0;
    end else if (clkEn) begin
      txLoad   <= 1'b0;
      if (!enMod) begin
        txSt    <= sct_pkg::TX_IDLE;
        txShReg <= 11'h7ff;
      end else if (tick) begin
        txPh <= txPh + 4'h1;
        if (txSt == sct_pkg::TX_IDLE) begin
          txPh <= 4'h0;
          if (teBit && brkBit) begin
            txSt    <= sct_pkg::TX_BRK;
            txShReg <= 11'h000;
            txBits  <= charLen;
          end else if (preStart) begin
            txSt     <= sct_pkg::TX_PRE;
            txShReg  <= 11'h7ff;
            txBits   <= charLen;
          end else if (teBit && txFullReg) begin
            txSt    <= sct_pkg::TX_DATA;
            txShReg <= frame(txBufReg, tx9Reg, longCh);
            txBits  <= charLen;
            txLoad  <= 1'b1;
          end
          tcReg <= !(teBit && (brkBit || txFullReg || idleQReg));
        end else if (txPh == `SCT_OVS) begin
          txShReg <= {1'b1, txShReg[10:1]};
          txBits  <= txBits - 4'h1;
          if (txBits == 4'h0) begin
            if (txSt == sct_pkg::TX_BRK && !brkBit) begin
              txSt    <= sct_pkg::TX_PRE;
              txShReg <= 11'h7ff;
              txBits  <= 4'h0;
            end else begin
              txSt <= sct_pkg::TX_IDLE;
            end
          end
        end
      end
    end
  end

  // pin drive, idle high, released when disabled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txdOut <= 1'b1;
      txdOe  <= 1'b0;
      txIrq  <= 1'b0;
      rxIrq  <= 1'b0;
    end else if (clkEn) begin
      txdOut <= (txSt == sct_pkg::TX_IDLE) ? 1'b1 : txShReg[0];
      txdOe  <= enMod;
      txIrq  <= txeReg && ctrl2Reg[`SCT_C2_TXIE] || tcReg && ctrl2Reg[`SCT_C2_TX_COMPLETE_IRQ_ENABLE];
      rxIrq  <= rxfReg && ctrl2Reg[`SCT_C2_RXIE];
    end
  end

  // receive pin synchroniser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxS1 <= 1'b1;
      rxS2 <= 1'b1;
    end else if (clkEn) begin
      rxS1 <= rxdPin;
      rxS2 <= rxS1;
    end
  end

  assign rxDone  = tick && rxSt == sct_pkg::RX_DATA && rxPh == `SCT_OVS && rxBits == 4'h0;
  assign rxBreak = rxDone && !rxS2 && rxShReg[9:1] == 9'h000;

  // receive engine, center sampling
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxSt    <= sct_pkg::RX_IDLE;
      rxPh    <= 4'h0;
      rxBits  <= 4'h0;
      rxShReg <= 10'h000;
    end else if (clkEn) begin
      if (!enMod || !ctrl2Reg[`SCT_C2_RXEN]) begin
        rxSt <= sct_pkg::RX_IDLE;
      end else if (tick) begin
        rxPh <= rxPh + 4'h1;
        if (rxSt == sct_pkg::RX_IDLE) begin
          rxPh <= 4'h0;
          if (!rxS2) begin
            rxSt <= sct_pkg::RX_START;
          end
        end else if (rxSt == sct_pkg::RX_START && rxPh == `SCT_MID) begin
          rxSt   <= rxS2 ? sct_pkg::RX_IDLE : sct_pkg::RX_DATA;
          rxPh   <= 4'h0;
          rxBits <= charLen - 4'h1;
        end else if (rxSt == sct_pkg::RX_DATA && rxPh == `SCT_OVS && rxBits != 4'h0) begin
          rxShReg <= longCh ? {rxS2, rxShReg[9:1]} : {1'b0, rxS2, rxShReg[8:1]};
          rxBits  <= rxBits - 4'h1;
        end else if (rxDone) begin
          rxSt <= sct_pkg::RX_IDLE;
        end
      end
    end
  end

  // receive buffer and flags, set wins over clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxBufReg <= 8'h00;
      rx9Reg   <= 1'b0;
      rxfReg   <= 1'b0;
      feReg    <= 1'b0;
      nfReg    <= 1'b0;
      bkfReg   <= 1'b0;
    end else if (clkEn) begin
      if (regRd && regAddr == `SCT_OFF_DATA) begin
        rxfReg <= 1'b0;
        feReg  <= 1'b0;
      end
      if (regRd && regAddr == `SCT_OFF_STAT2) begin
        bkfReg <= 1'b0;
      end
      if (rxDone) begin
        rxfReg <= 1'b1;
        feReg  <= !rxS2;
        if (rxBreak) begin
          rxBufReg <= 8'h00;
          rx9Reg   <= 1'b0;
          bkfReg   <= 1'b1;
        end else begin
          rxBufReg <= longCh ? rxShReg[8:1] : rxShReg[8:1];
          rx9Reg   <= longCh ? rxShReg[9] : rxShReg[8];
        end
      end
    end
  end

  // transmit checks
  a_txe_set: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && txLoad
    |=> txeReg) else $error("empty flag not set on load");

  a_txe_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && dataWr && stat1SeenReg && !txLoad
    |=> !txeReg) else $error("empty flag not cleared");

  a_tx_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && txeReg && ctrl2Reg[`SCT_C2_TXIE]
    |=> txIrq) else $error("tx irq missing");

  a_start_bit: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && txLoad
    |-> !txShReg[0] && (longCh ? txShReg[10] : txShReg[9])) else $error("start or stop bad");

  a_ninth_tx: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && txLoad && longCh
    |-> txShReg[9] == $past(tx9Reg)) else $error("ninth bit wrong");

  a_idle_high: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && $past(clkEn) && $past(txSt) == sct_pkg::TX_IDLE
    |-> txdOut) else $error("idle low");

  a_pin_release: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && !enMod
    |=> !txdOe) else $error("pin not released");

  a_pin_drive: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && enMod
    |=> txdOe) else $error("pin not driven");

  a_preamble: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && preStart
    |=> txSt == sct_pkg::TX_PRE && txShReg == 11'h7ff) else $error("no preamble");

  a_pre_ones: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && txSt == sct_pkg::TX_PRE
    |-> txShReg[0]) else $error("idle char not high");

  a_break_load: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && tick && enMod && txSt == sct_pkg::TX_IDLE && teBit && brkBit
    |=> txSt == sct_pkg::TX_BRK && txShReg == 11'h000) else $error("break not loaded");

  a_break_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && txSt == sct_pkg::TX_BRK
    |-> !txShReg[0]) else $error("break char not low");

  a_break_tail: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && tick && enMod && txSt == sct_pkg::TX_BRK && txPh == `SCT_OVS
    && txBits == 4'h0 && !brkBit
    |=> txSt == sct_pkg::TX_PRE && txShReg[0]) else $error("no high after break");

  a_tx_finish: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && enMod && txSt == sct_pkg::TX_DATA && !(tick && txPh == `SCT_OVS && txBits == 4'h0)
    |=> txSt == sct_pkg::TX_DATA) else $error("char cut short");

  a_idle_queue: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && teBit && !teDlyReg
    |=> idleQReg) else $error("idle not queued");

  a_tc_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && tick && enMod && txSt == sct_pkg::TX_IDLE && teBit && txFullReg
    |=> !tcReg) else $error("complete flag stays set");

  a_tc_set: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && tick && enMod && txSt == sct_pkg::TX_IDLE && !teBit
    |=> tcReg) else $error("complete flag not set");

  // receive checks
  a_rx_full: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && rxDone
    |=> rxfReg) else $error("full flag not set");

  a_ninth_rx: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && rxDone && !rxBreak && !longCh
    |=> rx9Reg == rxBufReg[7]) else $error("rx ninth bit not copy");

  a_rx_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && rxfReg && ctrl2Reg[`SCT_C2_RXIE]
    |=> rxIrq) else $error("rx irq missing");

  a_break_data: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && rxBreak
    |=> rxBufReg == 8'h00 && !rx9Reg && bkfReg && feReg && rxfReg) else $error("break effects");

  a_fe_with_full: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && rxDone
    |=> rxfReg && feReg == !$past(rxS2)) else $error("fe mismatch");
endmodule // sct_core

// ---- verif/sct_remote.sv ----
// remote serial device model on the far side of the core's serial pins
`timescale 1ns/1ps
module sct_remote #(
  parameter int BIT_CYC = 16
) (
  input  wire logic       mclk,
  input  wire logic       lineIn,
  input  wire logic       nineBit,
  output logic            lineOut,
  output logic [8:0]      rxData,
  output logic            rxStop,
  output int              rxCount
);
  initial begin
    lineOut = 1'b1;
    rxData  = '0;
    rxStop  = 1'b0;
    rxCount = 0;
  end

  // start low, data lsb first, stop level as given, then idle high
  task automatic send(input logic [8:0] d, input logic stopBit);
    int i;
    lineOut <= 1'b0;
    repeat (BIT_CYC) @(posedge mclk);
    for (i = 0; i < (nineBit ? 9 : 8); i++) begin
      lineOut <= d[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
    lineOut <= stopBit;
    repeat (BIT_CYC) @(posedge mclk);
    lineOut <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge mclk);
  endtask

  // mid-bit sampling of frames from the core
  always begin
    @(negedge lineIn);
    repeat (BIT_CYC / 2) @(posedge mclk);
    rxData = '0;
    for (int i = 0; i < (nineBit ? 9 : 8); i++) begin
      repeat (BIT_CYC) @(posedge mclk);
      rxData[i] = lineIn;
    end
    repeat (BIT_CYC) @(posedge mclk);
    rxStop = lineIn;
    rxCount++;
  end
endmodule // sct_remote

// ---- verif/sct_core_tb.sv ----
// self-checking bench for the serial core with a remote device model
`timescale 1ns/1ps
`include "sct_map.svh"
module sct_core_tb;
  logic                   mclk;
  logic                   rst_n;
  logic [`SCT_ADDR_W-1:0] regAddr;
  logic [7:0]             regWdata;
  logic                   regWr;
  logic                   regRd;
  logic [7:0]             regRdata;
  logic                   rxdPin;
  logic                   txdOut;
  logic                   txdOe;
  logic                   txIrq;
  logic                   rxIrq;
  logic                   nineBit;
  logic [8:0]             rxData;
  logic                   rxStop;
  int                     rxCount;
  int                     base;
  int                     failures;
  int                     comparisons;
  logic [7:0]             v;
  logic                   seenLow;
  wire                    txLine;

  // tri-state pin, drives both levels while enabled, pull-up when released
  assign txLine = txdOe ? txdOut : 1'b1;

  sct_core sct_core_i (.mclk(mclk), .rst_n(rst_n), .clkEn(1'b1), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .rxdPin(rxdPin), .txdOut(txdOut), .txdOe(txdOe), .txIrq(txIrq), .rxIrq(rxIrq));

  sct_remote sct_remote_i (.mclk(mclk), .lineIn(txLine), .nineBit(nineBit),
    .lineOut(rxdPin), .rxData(rxData), .rxStop(rxStop), .rxCount(rxCount));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic wrap_up();
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [`SCT_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr    <= 1'b0;
  endtask

  task automatic rd(input logic [`SCT_ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge mclk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd   <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic rdChk(input logic [`SCT_ADDR_W-1:0] a, input logic [7:0] exp);
    rd(a, v);
    chk({1'b0, v}, {1'b0, exp});
  endtask

  task automatic pollS1(input int b);
    for (int n = 0; n < 3000; n++) begin
      rd(`SCT_OFF_STAT1, v);
      if (v[b] === 1'b1) return;
    end
    failures++;
    wrap_up();
  endtask

  task automatic waitFrame(input logic [8:0] exp, input logic stopBit);
    for (int k = 0; k < 6000 && rxCount == base; k++) @(posedge mclk);
    if (rxCount == base) begin
      failures++;
      wrap_up();
    end
    chk(rxData, exp);
    chk({8'h00, rxStop}, {8'h00, stopBit});
  endtask

  task automatic txByte(input logic [7:0] d, input logic [8:0] exp);
    base = rxCount;
    rd(`SCT_OFF_STAT1, v);
    wr(`SCT_OFF_DATA, d);
    waitFrame(exp, 1'b1);
    pollS1(`SCT_S1_TC);
  endtask

  initial begin
    rst_n    = 1'b0;
    regAddr  = '0;
    regWdata = '0;
    regWr    = 1'b0;
    regRd    = 1'b0;
    nineBit  = 1'b0;
    failures = 0;
    comparisons = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rdChk(`SCT_OFF_STAT1, 8'hc0);
    chk({8'h00, txdOe}, 9'h000);
    wr(3'h7, 8'hff);
    rdChk(3'h7, 8'h00);
    wr(`SCT_OFF_BAUD, 8'h00);
    wr(`SCT_OFF_CTRL1, 8'h40);
    base = rxCount;
    rd(`SCT_OFF_STAT1, v);
    wr(`SCT_OFF_CTRL2, 8'h2c);
    wr(`SCT_OFF_DATA, 8'ha5);
    rdChk(`SCT_OFF_STAT1, 8'h00);
    chk({8'h00, txdOe}, 9'h001);
    seenLow = 1'b0;
    repeat (128) begin
      @(posedge mclk);
      seenLow = seenLow | ~txLine;
    end
    chk({8'h00, seenLow}, 9'h000);
    waitFrame(9'h0a5, 1'b1);
    pollS1(`SCT_S1_TC);
    chk({1'b0, v}, 9'h0c0);
    wr(`SCT_OFF_CTRL2, 8'hac);
    repeat (2) @(posedge mclk);
    chk({8'h00, txIrq}, 9'h001);
    wr(`SCT_OFF_CTRL2, 8'h2c);
    repeat (2) @(posedge mclk);
    chk({8'h00, txIrq}, 9'h000);
    sct_remote_i.send(9'h0c3, 1'b1);
    pollS1(`SCT_S1_RXF);
    chk({8'h00, rxIrq}, 9'h001);
    rdChk(`SCT_OFF_STAT1, 8'he0);
    rdChk(`SCT_OFF_CTRL3, 8'h80);
    rdChk(`SCT_OFF_DATA, 8'hc3);
    repeat (2) @(posedge mclk);
    chk({8'h00, rxIrq}, 9'h000);
    sct_remote_i.send(9'h000, 1'b0);
    pollS1(`SCT_S1_RXF);
    rdChk(`SCT_OFF_STAT1, 8'he2);
    rdChk(`SCT_OFF_STAT2, 8'h02);
    rdChk(`SCT_OFF_CTRL3, 8'h00);
    rdChk(`SCT_OFF_DATA, 8'h00);
    nineBit = 1'b1;
    wr(`SCT_OFF_CTRL1, 8'h50);
    wr(`SCT_OFF_CTRL3, 8'h40);
    txByte(8'h0f, 9'h10f);
    sct_remote_i.send(9'h155, 1'b1);
    pollS1(`SCT_S1_RXF);
    rdChk(`SCT_OFF_CTRL3, 8'hc0);
    rdChk(`SCT_OFF_DATA, 8'h55);
    base = rxCount;
    wr(`SCT_OFF_CTRL2, 8'h2d);
    waitFrame(9'h000, 1'b0);
    wr(`SCT_OFF_CTRL2, 8'h2c);
    txByte(8'h81, 9'h181);
    wr(`SCT_OFF_CTRL2, 8'h24);
    wr(`SCT_OFF_CTRL2, 8'h2c);
    txByte(8'h3c, 9'h13c);
    wr(`SCT_OFF_CTRL1, 8'h00);
    repeat (2) @(posedge mclk);
    chk({8'h00, txdOe}, 9'h000);
    wrap_up();
  end
endmodule // sct_core_tb
